// ### logic/rru_top.sv
// Rotate-right datapath slice with an Avalon-MM register slave.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rru_defines.svh"
module rru_top import rru_pkg::*; (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire rru_bus_req_s bus_i,
  output logic              waitrequest_o,
  output logic       [31:0] readdata_o
);
  logic        [31:0] oper_q;
  logic        [31:0] op_q;
  logic        [31:0] val_q;
  logic        [31:0] rdata_q;
  logic        [31:0] wmask;
  logic        [31:0] step_val;
  logic        [31:0] load_val;
  logic        [15:0] word;
  logic        [15:0] pre;
  rru_flags_s         flags_q;
  rru_state_e         st_q;
  rru_size_e          size_q;
  rru_size_e          dec_size;
  logic               through_q;
  logic               two_q;
  logic               msb0_q;
  logic               done_q;
  logic               illegal_q;
  logic               ack_q;
  logic               acc;
  logic               wr_ok;
  logic               idle;
  logic               last;
  logic               step_c;
  logic               is_long;
  logic               is_short;
  logic               dec_legal;
  logic               start_req;
  logic               go;
  logic               bad;

  function automatic logic msb_of(input logic [31:0] v, input rru_size_e s);
    case (s)
      RRU_SIZE_BYTE: msb_of = v[`RRU_MSB_BYTE];
      RRU_SIZE_WORD: msb_of = v[`RRU_MSB_WORD];
      default:       msb_of = v[`RRU_MSB_LONG];
    endcase
  endfunction

  function automatic logic [31:0] mask_of(input rru_size_e s);
    case (s)
      RRU_SIZE_BYTE: mask_of = `RRU_MASK_BYTE;
      RRU_SIZE_WORD: mask_of = `RRU_MASK_WORD;
      default:       mask_of = `RRU_MASK_LONG;
    endcase
  endfunction

  // Every access waits exactly one cycle; read data is registered in that cycle.
  assign acc           = bus_i.read | bus_i.write;
  assign waitrequest_o = acc & ~ack_q;
  assign wr_ok         = bus_i.write & ack_q;
  assign readdata_o    = rdata_q;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc & ~ack_q;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign wmask[8*g +: 8] = {8{bus_i.byteenable[g]}};
  end

  // Opcode decode from the software-written instruction and prefix words.
  assign word     = op_q[15:0];
  assign pre      = op_q[31:16];
  assign is_long  = (pre == `RRU_PREFIX_LONG) && (word[15:8] == `RRU_HEAD_LONG);
  assign is_short = (pre == `RRU_PREFIX_NONE) && (word[15:9] == `RRU_HEAD_SHORT);
  // two-bit kind field selects carry or plain
  assign dec_legal = (is_long || is_short) && !word[`RRU_ZERO_BIT]
                     && ((word[`RRU_KIND_HI:`RRU_KIND_LO] == `RRU_KIND_CARRY)
                      || (word[`RRU_KIND_HI:`RRU_KIND_LO] == `RRU_KIND_PLAIN));

  always_comb begin
    // size bit picks byte or word
    if (is_long) begin
      dec_size = RRU_SIZE_LONG;
    end else if (word[`RRU_W_BIT]) begin
      dec_size = RRU_SIZE_WORD;
    end else begin
      dec_size = RRU_SIZE_BYTE;
    end
  end

  assign idle      = (st_q == RRU_ST_IDLE);
  assign start_req = wr_ok && (bus_i.address == `RRU_OFS_CTRL) && bus_i.byteenable[0]
                     && bus_i.writedata[`RRU_CTRL_START] && idle;
  assign go        = start_req && dec_legal;
  assign bad       = start_req && !dec_legal;
  assign load_val  = oper_q & mask_of(dec_size);
  assign last      = ((st_q == RRU_ST_STEP1) && !two_q) || (st_q == RRU_ST_STEP2);

  rru_step i_rru_step (
    .val_i     (val_q),
    .carry_i   (flags_q.c),
    .size_i    (size_q),
    .through_i (through_q),
    .val_o     (step_val),
    .carry_o   (step_c)
  );

  // one or two steps from the count bit
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= RRU_ST_IDLE;
    end else begin
      case (st_q)
        RRU_ST_IDLE:  st_q <= go ? RRU_ST_STEP1 : RRU_ST_IDLE;
        RRU_ST_STEP1: st_q <= two_q ? RRU_ST_STEP2 : RRU_ST_IDLE;
        RRU_ST_STEP2: st_q <= RRU_ST_IDLE;
        default:      st_q <= RRU_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      size_q    <= RRU_SIZE_BYTE;
      through_q <= 1'b0;
      two_q     <= 1'b0;
      msb0_q    <= 1'b0;
    end else if (go) begin
      size_q    <= dec_size;
      through_q <= (word[`RRU_KIND_HI:`RRU_KIND_LO] == `RRU_KIND_CARRY);
      two_q     <= word[`RRU_S_BIT];
      msb0_q    <= msb_of(load_val, dec_size);
    end
  end

  // operand rotates one step per busy cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      val_q <= `RRU_RST_WORD;
    end else if (go) begin
      val_q <= load_val;
    end else if (!idle) begin
      val_q <= step_val;
    end
  end

  // Flags are writable only while idle so software can seed the carry.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      flags_q <= '0;
    end else if (!idle) begin
      flags_q.c <= step_c;
      if (last) begin
        flags_q.z <= (step_val == `RRU_RST_WORD);
        flags_q.s <= msb_of(step_val, size_q);
        flags_q.v <= msb0_q ^ msb_of(step_val, size_q);
      end
    end else if (wr_ok && (bus_i.address == `RRU_OFS_FLAGS) && bus_i.byteenable[0]) begin
      flags_q <= bus_i.writedata[3:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      if (last) begin
        done_q <= 1'b1;
      end else if (start_req) begin
        done_q <= 1'b0;
      end
      if (bad) begin
        illegal_q <= 1'b1;
      end else if (go) begin
        illegal_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      oper_q <= `RRU_RST_WORD;
      op_q   <= `RRU_RST_WORD;
    end else if (wr_ok) begin
      if (bus_i.address == `RRU_OFS_OPERAND) begin
        oper_q <= (oper_q & ~wmask) | (bus_i.writedata & wmask);
      end
      if (bus_i.address == `RRU_OFS_OPCODE) begin
        op_q <= (op_q & ~wmask) | (bus_i.writedata & wmask);
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= `RRU_RST_WORD;
    end else if (bus_i.read && !ack_q) begin
      rdata_q <= `RRU_RST_WORD;
      case (bus_i.address)
        `RRU_OFS_OPERAND: rdata_q <= oper_q;
        `RRU_OFS_OPCODE:  rdata_q <= op_q;
        `RRU_OFS_FLAGS:   rdata_q[3:0] <= flags_q;
        `RRU_OFS_RESULT:  rdata_q <= val_q;
        `RRU_OFS_STATUS: begin
          rdata_q[`RRU_STAT_BUSY]                   <= !idle;
          rdata_q[`RRU_STAT_DONE]                   <= done_q;
          rdata_q[`RRU_STAT_ILLEGAL]                <= illegal_q;
          rdata_q[`RRU_STAT_REG_HI:`RRU_STAT_REG_LO] <= word[`RRU_REG_HI:`RRU_REG_LO];
        end
        default:          rdata_q <= `RRU_RST_WORD;
      endcase
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_count_one;
    go && !word[`RRU_S_BIT] |-> ##2 (idle && done_q);
  endproperty
  a_count_one: assert property (p_count_one) else $error("one-step rotate did not finish in two cycles");

  property p_count_two;
    go && word[`RRU_S_BIT] |-> ##1 !idle ##1 !idle ##1 (idle && done_q);
  endproperty
  a_count_two: assert property (p_count_two) else $error("two-step rotate took the wrong time");

  property p_step_carry;
    !idle |=> flags_q.c == $past(val_q[0]);
  endproperty
  a_step_carry: assert property (p_step_carry) else $error("carry not loaded from bit zero");

  property p_top_carry;
    !idle && through_q |=> msb_of(val_q, size_q) == $past(flags_q.c);
  endproperty
  a_top_carry: assert property (p_top_carry) else $error("old carry did not enter top bit");

  property p_top_plain;
    !idle && !through_q |=> msb_of(val_q, size_q) == $past(val_q[0]);
  endproperty
  a_top_plain: assert property (p_top_plain) else $error("plain rotate top bit wrong");

  property p_final_carry;
    last |=> flags_q.c == $past(val_q[0]) && done_q;
  endproperty
  a_final_carry: assert property (p_final_carry) else $error("final carry is not last bit out");

  property p_zero;
    $rose(done_q) |-> flags_q.z == (val_q == `RRU_RST_WORD);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag disagrees with result");

  property p_sign;
    $rose(done_q) |-> flags_q.s == msb_of(val_q, size_q);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag disagrees with top bit");

  property p_ovf;
    $rose(done_q) |-> flags_q.v == (msb0_q ^ msb_of(val_q, size_q));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_decode;
    start_req && !dec_legal |=> illegal_q && idle;
  endproperty
  a_decode: assert property (p_decode) else $error("illegal opcode was executed");

  property p_long_prefix;
    go && (pre != `RRU_PREFIX_LONG) |=> size_q != RRU_SIZE_LONG;
  endproperty
  a_long_prefix: assert property (p_long_prefix) else $error("longword chosen without prefix");

endmodule

// ### common/rru_defines.svh
// Constants for the rotate-right datapath slice: offsets, opcode fields, widths and resets.
//
// Contract
// - Through-carry ring is operand plus carry, rotated right by the encoded one or two.
// - Each step: carry takes bit zero, bits shift down, old carry enters top.
// - Count-select bit clear means one position, set means two positions.
// - Final carry is the last bit shifted out of bit zero.
// - Zero flag set exactly when the whole rotated result is zero.
// - Sign flag copies the result's top bit at the selected width.
// - Overflow flag set when the top bit differs between start and end.
// - Opcode field 10 11001 W with nibble 11 S 0 selects rotate-through-carry.
// - Plain rotate: bit zero goes to top and to carry; old carry unused.
`ifndef RRU_DEFINES_SVH
`define RRU_DEFINES_SVH

`define RRU_OFS_OPERAND   8'h00
`define RRU_OFS_OPCODE    8'h04
`define RRU_OFS_CTRL      8'h08
`define RRU_OFS_FLAGS     8'h0C
`define RRU_OFS_RESULT    8'h10
`define RRU_OFS_STATUS    8'h14

`define RRU_RST_WORD      32'h0000_0000
`define RRU_CTRL_START    0
`define RRU_STAT_BUSY     0
`define RRU_STAT_DONE     1
`define RRU_STAT_ILLEGAL  2
`define RRU_STAT_REG_LO   4
`define RRU_STAT_REG_HI   7

`define RRU_PREFIX_LONG   16'h7A02
`define RRU_PREFIX_NONE   16'h0000
`define RRU_HEAD_SHORT    7'h59
`define RRU_HEAD_LONG     8'hB3
`define RRU_KIND_CARRY    2'h3
`define RRU_KIND_PLAIN    2'h1
`define RRU_W_BIT         8
`define RRU_REG_LO        4
`define RRU_REG_HI        7
`define RRU_KIND_LO       2
`define RRU_KIND_HI       3
`define RRU_S_BIT         1
`define RRU_ZERO_BIT      0

`define RRU_MSB_BYTE      7
`define RRU_MSB_WORD      15
`define RRU_MSB_LONG      31
`define RRU_MASK_BYTE     32'h0000_00FF
`define RRU_MASK_WORD     32'h0000_FFFF
`define RRU_MASK_LONG     32'hFFFF_FFFF

`endif

// ### common/rru_pkg.sv
// Types shared by the rotate-right datapath slice.
package rru_pkg;

  typedef enum logic [1:0] {
    RRU_SIZE_BYTE = 2'h0,
    RRU_SIZE_WORD = 2'h1,
    RRU_SIZE_LONG = 2'h2
  } rru_size_e;

  typedef enum logic [1:0] {
    RRU_ST_IDLE  = 2'h0,
    RRU_ST_STEP1 = 2'h1,
    RRU_ST_STEP2 = 2'h3
  } rru_state_e;

  typedef struct packed {
    logic v;
    logic s;
    logic z;
    logic c;
  } rru_flags_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rru_bus_req_s;

endpackage

// ### logic/rru_step.sv
// One single-position right rotate step, plain or through carry.
`timescale 1ns/1ps
`include "rru_defines.svh"
module rru_step import rru_pkg::*; (
  input  wire logic [31:0] val_i,
  input  wire logic        carry_i,
  input  wire rru_size_e   size_i,
  input  wire logic        through_i,
  output logic      [31:0] val_o,
  output logic             carry_o
);
  logic top;

  always_comb begin
    carry_o = val_i[0];
    // plain rotate feeds bit zero back
    top     = through_i ? carry_i : val_i[0];
    // Bits above the width are zero from the load, so the shift keeps them zero.
    val_o   = {1'b0, val_i[31:1]};
    case (size_i)
      RRU_SIZE_BYTE: val_o[`RRU_MSB_BYTE] = top;
      RRU_SIZE_WORD: val_o[`RRU_MSB_WORD] = top;
      RRU_SIZE_LONG: val_o[`RRU_MSB_LONG] = top;
      default:       val_o[`RRU_MSB_LONG] = top;
    endcase
  end
endmodule

// ### dv/rotate_right_unit_test.sv
// Self-checking bench for the rotate-right datapath slice over its register bus.
`timescale 1ns/1ps
`include "rru_defines.svh"
module rotate_right_unit_test;
  import rru_pkg::*;

  logic         clock_i;
  logic         reset_i;
  rru_bus_req_s bus_q;
  logic         waitrequest_o;
  logic  [31:0] readdata_o;
  int           mismatches;
  int           n_tests;
  int           cycles;

  rru_top i_rru_top (
    .clock_i       (clock_i),
    .reset_i       (reset_i),
    .bus_i         (bus_q),
    .waitrequest_o (waitrequest_o),
    .readdata_o    (readdata_o)
  );

  always #2.5 clock_i = ~clock_i;

  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run forever.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request stays put until the edge that sees waitrequest low; data is taken there.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_i);
    bus_q.read       <= !wr;
    bus_q.write      <= wr;
    bus_q.address    <= a;
    bus_q.writedata  <= d;
    bus_q.byteenable <= 4'hF;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    r = readdata_o;
    bus_q.read  <= 1'b0;
    bus_q.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask

  // Returns {V, S, Z, C, result} for a ring rotated right by n places.
  function automatic logic [35:0] model(logic [31:0] x, int msb, logic thr, int n, logic c);
    logic [31:0] v;
    logic        top0;
    logic        b;
    v = x & 32'((64'h1 << (msb + 1)) - 1);
    top0 = v[msb];
    repeat (n) begin
      b = v[0];
      v = v >> 1;
      v[msb] = thr ? c : b;
      c = b;
    end
    return {v[msb] ^ top0, v[msb], v == 32'h0000_0000, c, v};
  endfunction

  task automatic run(input logic lng, input logic w, input logic thr, input logic s,
                     input logic [3:0] rg, input logic [31:0] x, input logic c);
    logic [31:0] r;
    logic [31:0] op;
    logic [35:0] e;
    logic [1:0]  kind;
    int          msb;
    int          k;
    kind = thr ? `RRU_KIND_CARRY : `RRU_KIND_PLAIN;
    msb = lng ? 31 : (w ? 15 : 7);
    if (lng) begin
      op = {`RRU_PREFIX_LONG, `RRU_HEAD_LONG, rg, kind, s, 1'b0};
    end else begin
      op = {`RRU_PREFIX_NONE, `RRU_HEAD_SHORT, w, rg, kind, s, 1'b0};
    end
    e = model(x, msb, thr, s ? 2 : 1, c);
    wr(`RRU_OFS_OPERAND, x);
    wr(`RRU_OFS_OPCODE, op);
    wr(`RRU_OFS_FLAGS, {31'h0000_0000, c});
    wr(`RRU_OFS_CTRL, 32'h0000_0001);
    k = 0;
    do begin
      rd(`RRU_OFS_STATUS, r);
      k++;
    end while (r[1] !== 1'b1 && k < 10);
    chk({r[7:4], r[2:0]}, {25'h000_0000, rg, 3'b010});
    rd(`RRU_OFS_RESULT, r);
    chk(r, e[31:0]);
    rd(`RRU_OFS_FLAGS, r);
    chk(r[3:0], e[35:32]);
  endtask

  initial begin
    logic [31:0] r;
    clock_i = 1'b0;
    reset_i = 1'b1;
    bus_q   = '0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    rd(`RRU_OFS_OPERAND, r);
    chk(r, 32'h0000_0000);
    rd(`RRU_OFS_FLAGS, r);
    chk(r, 32'h0000_0000);
    rd(`RRU_OFS_STATUS, r);
    chk(r, 32'h0000_0000);
    // Unmapped places read zero and swallow writes.
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, r);
    chk(r, 32'h0000_0000);
    run(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 32'h0000_00DD, 1'b0);
    // Whole status word: idle, done, legal, register field zero, upper bits clear.
    rd(`RRU_OFS_STATUS, r);
    chk(r, 32'h0000_0002);
    rd(`RRU_OFS_RESULT, r);
    chk(r, 32'h0000_8037);
    run(1'b0, 1'b0, 1'b0, 1'b0, 4'h6, 32'h0000_0031, 1'b0);
    rd(`RRU_OFS_RESULT, r);
    chk(r, 32'h0000_0098);
    run(1'b0, 1'b0, 1'b1, 1'b0, 4'h2, 32'h0000_0001, 1'b0);
    run(1'b0, 1'b0, 1'b1, 1'b1, 4'h3, 32'h0000_0081, 1'b1);
    run(1'b0, 1'b1, 1'b0, 1'b1, 4'h5, 32'h0000_8001, 1'b1);
    run(1'b1, 1'b0, 1'b1, 1'b0, 4'hA, 32'h8000_0001, 1'b1);
    run(1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 32'hFFFF_FFFF, 1'b0);
    run(1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 32'h0000_FF02, 1'b1);
    run(1'b0, 1'b1, 1'b1, 1'b1, 4'h7, 32'h0000_0000, 1'b1);
    // A word that matches neither encoding must be refused.
    wr(`RRU_OFS_OPCODE, 32'h0000_0000);
    wr(`RRU_OFS_CTRL, 32'h0000_0001);
    rd(`RRU_OFS_STATUS, r);
    chk(r[2:0], 32'h0000_0004);
    rd(`RRU_OFS_CTRL, r);
    chk(r, 32'h0000_0000);
    report_and_stop();
  end
endmodule
